// ---- hw/wfg_pkg.sv ----
// constants, types and register map of the wobble frequency generator
package wfg_pkg;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES  = TICK_TIME_US * CLK_FREQ_MHZ;
    localparam int MIN_TICK     = 256;
    // one wobble period unit is 0.1 s, in 1 ms ticks
    localparam logic [7:0]  TICKS_PER_UNIT = 8'h64;
    localparam logic [23:0] PCT_SCALE      = 24'h0003E8;
    localparam logic [23:0] PCT_TO_MS      = 24'h00000A;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_AMPL   = 12'h004;
    localparam logic [11:0] ADDR_STEP   = 12'h008;
    localparam logic [11:0] ADDR_PERIOD = 12'h00C;
    localparam logic [11:0] ADDR_RISE   = 12'h010;
    localparam logic [11:0] ADDR_CENTRE = 12'h014;
    localparam logic [11:0] ADDR_FMAX   = 12'h018;
    localparam logic [11:0] ADDR_UPPER  = 12'h01C;
    localparam logic [11:0] ADDR_LOWER  = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h024;
    localparam logic [11:0] ADDR_SPAN   = 12'h028;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int STAT_RISE_BIT = 16;
    localparam int STAT_ACT_BIT  = 17;

    localparam logic [15:0] AMPL_RST   = 16'h0000;
    localparam logic [15:0] STEP_RST   = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'h0064;
    localparam logic [15:0] RISE_RST   = 16'h01F4;
    localparam logic [15:0] CENTRE_RST = 16'h1388;
    localparam logic [15:0] FMAX_RST   = 16'h1388;
    localparam logic [15:0] UPPER_RST  = 16'h1388;
    localparam logic [15:0] LOWER_RST  = 16'h0000;

    localparam logic [15:0] AMPL_MAX   = 16'h03E8;
    localparam logic [15:0] STEP_MAX   = 16'h01F4;
    localparam logic [15:0] PERIOD_MIN = 16'h0001;
    localparam logic [15:0] PERIOD_MAX = 16'h7530;
    localparam logic [15:0] RISE_MIN   = 16'h0001;
    localparam logic [15:0] RISE_MAX   = 16'h03E8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SPAN = 3'b001,
        ST_STEP = 3'b010,
        ST_RISE = 3'b011,
        ST_RAMP = 3'b100,
        ST_OUT  = 3'b101
    } wfg_state_e;

    typedef struct packed {
        logic        enable;
        logic        swing_mode_select;
        logic [9:0]  swing_amplitude_pct;
        logic [9:0]  startup_step_pct;
        logic [14:0] wobble_period;
        logic [9:0]  rise_share_pct;
        logic [15:0] centre_frequency_reference;
        logic [15:0] maximum_output_frequency;
        logic [15:0] upper_limit;
        logic [15:0] lower_limit;
    } wfg_cfg_s;
endpackage

// ---- hw/wfg_top.sv ----
// wobble frequency generator with apb register slave
// Operation
// - output swings above and below centre reference
// - mode 0: span is centre times amplitude
// - mode 1: span is maximum times amplitude
// - amplitude 0..100.0 %, zero disables wobbling
// - startup step is span times step 0..50 %
// - output clamped to upper and lower limits
// - period 0.1..3000.0 s, rise plus fall
// - rise time is period times rise share
// - fall time is period times remaining share
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
module wfg_top #(
    parameter int TICK_CYCLES = wfg_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic      [15:0] freq_cmd_out,
    output logic             wobble_active_out,
    output logic             ramp_rising_out
);
    if (TICK_CYCLES < wfg_pkg::MIN_TICK || TICK_CYCLES > 2 ** 17) begin : g_chk
        $error("TICK_CYCLES outside what the tick counter can serve");
    end

    function automatic logic [15:0] lim(input logic [31:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
        if (v < {16'h0000, lo})
            lim = lo;
        else if (v > {16'h0000, hi})
            lim = hi;
        else
            lim = v[15:0];
    endfunction

    wfg_pkg::wfg_cfg_s   cfg_r;
    wfg_pkg::wfg_state_e state_r;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    logic        slverr_r;
    logic        hit;
    logic        wr_en;
    logic        active;
    logic [16:0] tick_cnt_r;
    logic        tick_pend_r;
    logic [21:0] elapsed_r;
    logic        rising_r;
    logic [15:0] span_r;
    logic [15:0] step_r;
    logic [21:0] rise_ms_r;
    logic [21:0] period_ms;
    logic [21:0] fall_ms;
    logic [21:0] dur_cur;
    logic [16:0] delta;
    logic [16:0] ramp_r;
    logic [15:0] freq_cmd_r;
    logic [15:0] base;
    logic [39:0] num_r;
    logic [24:0] rem_r;
    logic [23:0] den_r;
    logic [5:0]  div_cnt_r;
    logic        div_busy_r;
    logic        div_done_r;
    logic        issued_r;
    logic        div_go;
    logic [39:0] go_num;
    logic [23:0] go_den;
    logic [24:0] shifted;
    logic        fits;
    logic signed [18:0] off;
    logic signed [18:0] sum;

    // apb: registered read data, zero wait states
    assign wr_en       = psel_in & penable_in & pwrite_in;
    assign pready_out  = psel_in & penable_in;
    assign prdata_out  = prdata_r;
    assign pslverr_out = slverr_r;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit    = 1'b1;
        unique case (paddr_in)
            wfg_pkg::ADDR_CTRL: begin
                rd_nxt[wfg_pkg::CTRL_EN_BIT]   = cfg_r.enable;
                rd_nxt[wfg_pkg::CTRL_MODE_BIT] = cfg_r.swing_mode_select;
            end
            wfg_pkg::ADDR_AMPL:   rd_nxt[9:0]  = cfg_r.swing_amplitude_pct;
            wfg_pkg::ADDR_STEP:   rd_nxt[9:0]  = cfg_r.startup_step_pct;
            wfg_pkg::ADDR_PERIOD: rd_nxt[14:0] = cfg_r.wobble_period;
            wfg_pkg::ADDR_RISE:   rd_nxt[9:0]  = cfg_r.rise_share_pct;
            wfg_pkg::ADDR_CENTRE:
                rd_nxt[15:0] = cfg_r.centre_frequency_reference;
            wfg_pkg::ADDR_FMAX:
                rd_nxt[15:0] = cfg_r.maximum_output_frequency;
            wfg_pkg::ADDR_UPPER:  rd_nxt[15:0] = cfg_r.upper_limit;
            wfg_pkg::ADDR_LOWER:  rd_nxt[15:0] = cfg_r.lower_limit;
            wfg_pkg::ADDR_STATUS: begin
                rd_nxt[15:0] = freq_cmd_r;
                rd_nxt[wfg_pkg::STAT_RISE_BIT] = rising_r;
                rd_nxt[wfg_pkg::STAT_ACT_BIT]  = active;
            end
            wfg_pkg::ADDR_SPAN:   rd_nxt = {step_r, span_r};
            default:              hit = 1'b0;
        endcase
    end

    // captured in the setup cycle so the access phase needs no wait
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (psel_in && !penable_in) begin
            prdata_r <= pwrite_in ? 32'h0000_0000 : rd_nxt;
            slverr_r <= ~hit;
        end
    end

    // out-of-range amplitude, step, period and rise writes saturate instead of faulting
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r.enable                     <= 1'b0;
            cfg_r.swing_mode_select          <= 1'b0;
            cfg_r.swing_amplitude_pct        <= 10'(wfg_pkg::AMPL_RST);
            cfg_r.startup_step_pct           <= 10'(wfg_pkg::STEP_RST);
            cfg_r.wobble_period              <= 15'(wfg_pkg::PERIOD_RST);
            cfg_r.rise_share_pct             <= 10'(wfg_pkg::RISE_RST);
            cfg_r.centre_frequency_reference <= wfg_pkg::CENTRE_RST;
            cfg_r.maximum_output_frequency   <= wfg_pkg::FMAX_RST;
            cfg_r.upper_limit                <= wfg_pkg::UPPER_RST;
            cfg_r.lower_limit                <= wfg_pkg::LOWER_RST;
        end else if (wr_en) begin
            unique case (paddr_in)
                wfg_pkg::ADDR_CTRL: begin
                    cfg_r.enable <= pwdata_in[wfg_pkg::CTRL_EN_BIT];
                    cfg_r.swing_mode_select <=
                        pwdata_in[wfg_pkg::CTRL_MODE_BIT];
                end
                wfg_pkg::ADDR_AMPL: cfg_r.swing_amplitude_pct <= 10'(
                    lim(pwdata_in, 16'h0000, wfg_pkg::AMPL_MAX));
                wfg_pkg::ADDR_STEP: cfg_r.startup_step_pct <= 10'(
                    lim(pwdata_in, 16'h0000, wfg_pkg::STEP_MAX));
                wfg_pkg::ADDR_PERIOD: cfg_r.wobble_period <= 15'(
                    lim(pwdata_in, wfg_pkg::PERIOD_MIN,
                        wfg_pkg::PERIOD_MAX));
                wfg_pkg::ADDR_RISE: cfg_r.rise_share_pct <= 10'(
                    lim(pwdata_in, wfg_pkg::RISE_MIN,
                        wfg_pkg::RISE_MAX));
                wfg_pkg::ADDR_CENTRE:
                    cfg_r.centre_frequency_reference <= pwdata_in[15:0];
                wfg_pkg::ADDR_FMAX:
                    cfg_r.maximum_output_frequency <= pwdata_in[15:0];
                wfg_pkg::ADDR_UPPER: cfg_r.upper_limit <= pwdata_in[15:0];
                wfg_pkg::ADDR_LOWER: cfg_r.lower_limit <= pwdata_in[15:0];
                default: ;
            endcase
        end
    end

    assign active = cfg_r.enable
                  & (cfg_r.swing_amplitude_pct != 10'h000);

    // 1 ms tick; a tick during a busy chain is held, set beats clear
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_r  <= 17'h00000;
            tick_pend_r <= 1'b0;
        end else begin
            if (tick_cnt_r == 17'(TICK_CYCLES - 1)) begin
                tick_cnt_r  <= 17'h00000;
                tick_pend_r <= 1'b1;
            end else begin
                tick_cnt_r <= tick_cnt_r + 17'h00001;
                if (state_r == wfg_pkg::ST_IDLE)
                    tick_pend_r <= 1'b0;
            end
        end
    end

    assign period_ms = 22'(cfg_r.wobble_period) * 22'(wfg_pkg::TICKS_PER_UNIT);
    assign fall_ms   = period_ms - rise_ms_r;
    assign dur_cur   = rising_r ? rise_ms_r : fall_ms;
    assign delta     = 17'({span_r, 1'b0} - {1'b0, step_r});
    assign base      = cfg_r.swing_mode_select
                     ? cfg_r.maximum_output_frequency
                     : cfg_r.centre_frequency_reference;

    // one shared divider keeps area low; a chain takes about 170 cycles
    always_comb begin
        go_num = 40'h00_0000_0000;
        go_den = wfg_pkg::PCT_SCALE;
        unique case (state_r)
            wfg_pkg::ST_SPAN: go_num = 40'(base)
                * 40'(active ? cfg_r.swing_amplitude_pct : 10'h000);
            wfg_pkg::ST_STEP:
                go_num = 40'(span_r) * 40'(cfg_r.startup_step_pct);
            wfg_pkg::ST_RISE: begin
                go_num = 40'(cfg_r.wobble_period)
                       * 40'(cfg_r.rise_share_pct);
                go_den = wfg_pkg::PCT_TO_MS;
            end
            wfg_pkg::ST_RAMP: begin
                go_num = 40'(delta) * 40'(elapsed_r);
                go_den = {2'b00, dur_cur};
            end
            default: ;
        endcase
    end

    assign div_go = !issued_r && !div_busy_r
                  && (state_r == wfg_pkg::ST_SPAN
                      || state_r == wfg_pkg::ST_STEP
                      || state_r == wfg_pkg::ST_RISE
                      || (state_r == wfg_pkg::ST_RAMP
                          && dur_cur != 22'h000000));
    assign shifted = {rem_r[23:0], num_r[39]};
    assign fits    = shifted >= {1'b0, den_r};

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            num_r      <= 40'h00_0000_0000;
            rem_r      <= 25'h0000000;
            den_r      <= 24'h000000;
            div_cnt_r  <= 6'h00;
            div_busy_r <= 1'b0;
            div_done_r <= 1'b0;
        end else begin
            div_done_r <= 1'b0;
            if (div_go) begin
                num_r      <= go_num;
                rem_r      <= 25'h0000000;
                den_r      <= go_den;
                div_cnt_r  <= 6'h00;
                div_busy_r <= 1'b1;
            end else if (div_busy_r) begin
                rem_r <= fits ? shifted - {1'b0, den_r} : shifted;
                num_r <= {num_r[38:0], fits};
                div_cnt_r <= div_cnt_r + 6'h01;
                if (div_cnt_r == 6'h27) begin
                    div_busy_r <= 1'b0;
                    div_done_r <= 1'b1;
                end
            end
        end
    end

    // signed offset from centre, startup step applied at each turn
    always_comb begin
        if (rising_r)
            off = -$signed({3'b000, span_r}) + $signed({3'b000, step_r})
                + $signed({2'b00, ramp_r});
        else
            off = $signed({3'b000, span_r}) - $signed({3'b000, step_r})
                - $signed({2'b00, ramp_r});
        sum = $signed({3'b000, cfg_r.centre_frequency_reference})
            + off;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r    <= wfg_pkg::ST_IDLE;
            issued_r   <= 1'b0;
            elapsed_r  <= 22'h000000;
            rising_r   <= 1'b1;
            span_r     <= 16'h0000;
            step_r     <= 16'h0000;
            rise_ms_r  <= 22'h000000;
            ramp_r     <= 17'h00000;
            freq_cmd_r <= wfg_pkg::LOWER_RST;
        end else begin
            if (div_go)
                issued_r <= 1'b1;
            unique case (state_r)
                wfg_pkg::ST_IDLE: if (tick_pend_r) begin
                    state_r <= wfg_pkg::ST_SPAN;
                    if (!active) begin
                        elapsed_r <= 22'h000000;
                        rising_r  <= 1'b1;
                    end else if (elapsed_r + 22'h000001 >= dur_cur) begin
                        elapsed_r <= 22'h000000;
                        rising_r  <= ~rising_r;
                    end else begin
                        elapsed_r <= elapsed_r + 22'h000001;
                    end
                end
                wfg_pkg::ST_SPAN: if (div_done_r) begin
                    span_r   <= num_r[15:0];
                    issued_r <= 1'b0;
                    state_r  <= wfg_pkg::ST_STEP;
                end
                wfg_pkg::ST_STEP: if (div_done_r) begin
                    step_r   <= num_r[15:0];
                    issued_r <= 1'b0;
                    state_r  <= wfg_pkg::ST_RISE;
                end
                wfg_pkg::ST_RISE: if (div_done_r) begin
                    rise_ms_r <= num_r[21:0];
                    issued_r  <= 1'b0;
                    state_r   <= wfg_pkg::ST_RAMP;
                end
                wfg_pkg::ST_RAMP: begin
                    // zero-length ramp jumps straight to its end
                    if (dur_cur == 22'h000000) begin
                        ramp_r  <= delta;
                        state_r <= wfg_pkg::ST_OUT;
                    end else if (div_done_r) begin
                        ramp_r   <= num_r[16:0];
                        issued_r <= 1'b0;
                        state_r  <= wfg_pkg::ST_OUT;
                    end
                end
                wfg_pkg::ST_OUT: begin
                    // with crossed limits, lower wins only for sums below it, else upper wins
                    if (sum < $signed({3'b000, cfg_r.lower_limit}))
                        freq_cmd_r <= cfg_r.lower_limit;
                    else if (sum > $signed({3'b000, cfg_r.upper_limit}))
                        freq_cmd_r <= cfg_r.upper_limit;
                    else
                        freq_cmd_r <= sum[15:0];
                    issued_r <= 1'b0;
                    state_r  <= wfg_pkg::ST_IDLE;
                end
                default: state_r <= wfg_pkg::ST_IDLE;
            endcase
        end
    end

    assign freq_cmd_out      = freq_cmd_r;
    assign wobble_active_out = active;
    assign ramp_rising_out   = rising_r;
endmodule

// ---- tb/wfg_top_properties.sv ----
// port checks for the wobble frequency generator
`timescale 1ns/100ps
module wfg_chk #(
    parameter int TICK_CYCLES = 256
) (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [15:0] freq_cmd_out,
    input wire logic        wobble_active_out,
    input wire logic        ramp_rising_out
);
    logic        acc;
    logic        rdq;
    logic        wr;
    logic        en_r;
    logic        amp_nz_r;
    logic [15:0] up_r;
    logic [15:0] lo_r;
    logic [31:0] quiet_r;
    logic        quiet;
    assign acc = psel_in & penable_in;
    assign rdq = acc & ~pwrite_in;
    assign wr = acc & pwrite_in;
    // config lands one tick late, so limits are judged only once settled
    assign quiet = quiet_r >= 32'(3 * TICK_CYCLES);
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            quiet_r <= 32'h0;
        end else if (wr) begin
            quiet_r <= 32'h0;
        end else if (!quiet) begin
            quiet_r <= quiet_r + 32'h1;
        end
    end
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_r <= 1'b0;
            amp_nz_r <= 1'b0;
            up_r <= wfg_pkg::UPPER_RST;
            lo_r <= wfg_pkg::LOWER_RST;
        end else if (wr) begin
            if (paddr_in == wfg_pkg::ADDR_CTRL) en_r <= pwdata_in[0];
            if (paddr_in == wfg_pkg::ADDR_AMPL) amp_nz_r <= |pwdata_in;
            if (paddr_in == wfg_pkg::ADDR_UPPER) up_r <= pwdata_in[15:0];
            if (paddr_in == wfg_pkg::ADDR_LOWER) lo_r <= pwdata_in[15:0];
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    chk_ready_now: assert property (pready_out == acc)
        else $error("pready differs from access phase");
    chk_err_unmapped: assert property (
        acc && (paddr_in > wfg_pkg::ADDR_SPAN || paddr_in[1:0] != 2'b00)
        |-> pslverr_out)
        else $error("no error on unmapped access");
    chk_err_mapped: assert property (
        acc && paddr_in <= wfg_pkg::ADDR_SPAN && paddr_in[1:0] == 2'b00
        |-> !pslverr_out)
        else $error("error on mapped access");
    chk_clamp_limits: assert property (
        quiet && lo_r <= up_r && $changed(freq_cmd_out)
        |-> freq_cmd_out <= up_r && freq_cmd_out >= lo_r)
        else $error("frequency outside limits");
    chk_active_source: assert property (
        wobble_active_out == (en_r && amp_nz_r))
        else $error("active flag mismatch");
    chk_flip_spacing: assert property (
        $changed(ramp_rising_out) |=> $stable(ramp_rising_out) [*8])
        else $error("ramp direction flips too fast");
    chk_amp_range: assert property (
        rdq && paddr_in == wfg_pkg::ADDR_AMPL
        |-> prdata_out <= {16'h0000, wfg_pkg::AMPL_MAX})
        else $error("amplitude beyond range");
    chk_step_range: assert property (
        rdq && paddr_in == wfg_pkg::ADDR_STEP
        |-> prdata_out <= {16'h0000, wfg_pkg::STEP_MAX})
        else $error("step beyond range");
    chk_period_range: assert property (
        rdq && paddr_in == wfg_pkg::ADDR_PERIOD
        |-> prdata_out inside {[32'h1:32'h7530]})
        else $error("period beyond range");
    chk_span_half: assert property (
        rdq && paddr_in == wfg_pkg::ADDR_SPAN
        |-> {prdata_out[31:16], 1'b0} <= {1'b0, prdata_out[15:0]})
        else $error("startup step above half span");
    cov_fall: cover property ($fell(ramp_rising_out));
    cov_err: cover property (acc && pslverr_out);
    cov_active: cover property ($rose(wobble_active_out));
endmodule

bind wfg_top wfg_chk #(.TICK_CYCLES(TICK_CYCLES)) i_wfg_chk (.ref_clk_in,
    .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .freq_cmd_out,
    .wobble_active_out, .ramp_rising_out);

// ---- tb/wfg_drive_model.sv ----
// drive-side observer of the frequency command
`timescale 1ns/100ps
module wfg_drive_model (
    input  wire logic        ref_clk_in,
    input  wire logic        clear_in,
    input  wire logic [15:0] freq_in,
    output logic      [15:0] min_out,
    output logic      [15:0] max_out
);
    // speed loop only keeps the extremes it was commanded to
    always_ff @(posedge ref_clk_in) begin
        if (clear_in || freq_in < min_out) begin
            min_out <= freq_in;
        end
        if (clear_in || freq_in > max_out) begin
            max_out <= freq_in;
        end
    end
endmodule

// ---- tb/wfg_top_test.sv ----
// self-checking bench for the wobble frequency generator
`timescale 1ns/100ps
module wfg_top_test;
    localparam int T = 256;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic [15:0] freq_cmd_out;
    logic        wobble_active_out;
    logic        ramp_rising_out;
    logic        clr = 1'b0;
    logic [15:0] fmin;
    logic [15:0] fmax;
    logic [31:0] rd;
    logic        er;
    int          n_errors = 0;
    int          cmp_count = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    wfg_top #(.TICK_CYCLES(T)) i_wfg_top (.ref_clk_in, .rst_in, .psel_in,
        .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .freq_cmd_out, .wobble_active_out,
        .ramp_rising_out);
    wfg_drive_model i_wfg_drive_model (.ref_clk_in, .clear_in(clr),
        .freq_in(freq_cmd_out), .min_out(fmin), .max_out(fmax));
    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        @(posedge ref_clk_in);
        while (pready_out !== 1'b1) @(posedge ref_clk_in);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic t_reset();
        logic [11:0] a [9] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                               12'h014, 12'h018, 12'h01C, 12'h020};
        logic [31:0] e [9] = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h1F4,
                               32'h1388, 32'h1388, 32'h1388, 32'h0};
        for (int i = 0; i < 9; i++) begin
            rdc(a[i], e[i]);
        end
        rdc(12'h02C, 32'h0);
        chk({31'h0, er}, 32'h1);
        repeat (2 * T) @(posedge ref_clk_in);
        chk({16'h0, freq_cmd_out}, 32'h1388);
    endtask
    task automatic t_span();
        apb(1'b1, wfg_pkg::ADDR_CENTRE, 32'h3E8);
        apb(1'b1, wfg_pkg::ADDR_AMPL, 32'h64);
        apb(1'b1, wfg_pkg::ADDR_STEP, 32'h64);
        apb(1'b1, wfg_pkg::ADDR_CTRL, 32'h1);
        repeat (2 * T) @(posedge ref_clk_in);
        rdc(wfg_pkg::ADDR_SPAN, 32'h000A0064);
        chk({31'h0, wobble_active_out}, 32'h1);
        apb(1'b1, wfg_pkg::ADDR_CTRL, 32'h3);
        repeat (2 * T) @(posedge ref_clk_in);
        rdc(wfg_pkg::ADDR_SPAN, 32'h003201F4);
        apb(1'b1, wfg_pkg::ADDR_AMPL, 32'h7D0);
        rdc(wfg_pkg::ADDR_AMPL, 32'h3E8);
        apb(1'b1, wfg_pkg::ADDR_STEP, 32'h258);
        rdc(wfg_pkg::ADDR_STEP, 32'h1F4);
        apb(1'b1, wfg_pkg::ADDR_AMPL, 32'h0);
        repeat (2 * T) @(posedge ref_clk_in);
        rdc(wfg_pkg::ADDR_SPAN, 32'h0);
        chk({31'h0, wobble_active_out}, 32'h0);
        chk({16'h0, freq_cmd_out}, 32'h3E8);
        // idle: rising flag held, active clear, output at centre
        rdc(wfg_pkg::ADDR_STATUS, 32'h000103E8);
    endtask
    task automatic t_wobble(input logic [31:0] rise, input logic [31:0] up,
                            input logic [31:0] lo, input logic [15:0] emin,
                            input logic [15:0] emax, input int hi_ms,
                            input int lo_ms);
        int n;
        apb(1'b1, wfg_pkg::ADDR_RISE, rise);
        apb(1'b1, wfg_pkg::ADDR_UPPER, up);
        apb(1'b1, wfg_pkg::ADDR_LOWER, lo);
        apb(1'b1, wfg_pkg::ADDR_PERIOD, 32'h1);
        apb(1'b1, wfg_pkg::ADDR_AMPL, 32'h64);
        apb(1'b1, wfg_pkg::ADDR_STEP, 32'h64);
        apb(1'b1, wfg_pkg::ADDR_CTRL, 32'h1);
        // skip any ramp already under way, then time whole ones
        // falling first: the run then ends at a falling start, saving time
        while (ramp_rising_out === 1'b0) @(posedge ref_clk_in);
        while (ramp_rising_out === 1'b1) @(posedge ref_clk_in);
        clr <= 1'b1;
        @(posedge ref_clk_in);
        clr <= 1'b0;
        n = 1;
        for (; ramp_rising_out === 1'b0; n++) @(posedge ref_clk_in);
        chk(32'((n + T / 2) / T), 32'(lo_ms));
        for (n = 0; ramp_rising_out === 1'b1; n++) @(posedge ref_clk_in);
        chk(32'((n + T / 2) / T), 32'(hi_ms));
        chk({16'h0, fmin}, {16'h0, emin});
        chk({16'h0, fmax}, {16'h0, emax});
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_span();
        t_wobble(32'h1F4, 32'h1388, 32'h0, 16'h0388, 16'h0448,
                 50, 50);
        t_wobble(32'h320, 32'h41A, 32'h3B6, 16'h03B6, 16'h041A,
                 80, 20);
        finish_test();
    end
endmodule
